// ==== design/lcdrc_regs.sv ====
// LCD driver control and status register bank with an AHB-Lite slave port.
module lcdrc_regs
  import lcdrc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        frame_event,
  output logic             segment_orientation,
  output logic             common_orientation,
  output logic             display_area_select,
  output logic             reverse_video,
  output logic      [1:0]  display_mode,
  output logic      [3:0]  contrast_level,
  output logic      [1:0]  duty_select,
  output logic             heavy_load_protect,
  output logic             regulator_source,
  output logic             booster_enable,
  output logic             frame_irq
);

  logic        seg_orient_q;
  logic        com_orient_q;
  logic        area_select_q;
  logic        reverse_vid_q;
  logic [1:0]  display_mode_q;
  logic [3:0]  contrast_q;
  logic [1:0]  duty_q;
  logic        heavy_load_q;
  logic        reg_source_q;
  logic        booster_en_q;
  logic        frame_ie_q;
  logic        frame_if_q;
  logic        frame_if_d;
  logic        frame_irq_q;

  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [29:0] addr_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic        hresp_q;

  logic        addr_phase;
  logic        wr_fire;
  logic [7:0]  rd_mux;

  // Only whole-word transfers are expected; narrower sizes are served as words.
  assign addr_phase = hsel && hready && htrans[1];
  assign wr_fire    = wr_pend_q && hready;

  // Address phase capture; reads take one wait state so the returned data
  // always reflects a write that finished in the cycle before.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 30'h0000_0000;
    end else if (hready) begin
      wr_pend_q <= addr_phase && hwrite;
      rd_pend_q <= addr_phase && !hwrite;
      if (addr_phase) begin
        addr_q <= haddr[31:2];
      end
    end else begin
      rd_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q     <= LCDRC_HRESP_OKAY;
    end else begin
      hreadyout_q <= !(hready && addr_phase && !hwrite);
      hresp_q     <= LCDRC_HRESP_OKAY;
    end
  end

  // Read mux; reserved bits and unmapped addresses read as zero.
  always_comb begin
    rd_mux = 8'h00;
    case (addr_q)
      LCDRC_IDX_DISPLAY_CONTROL: begin
        rd_mux[LCDRC_POS_SEG_ORIENT]  = seg_orient_q;
        rd_mux[LCDRC_POS_COM_ORIENT]  = com_orient_q;
        rd_mux[LCDRC_POS_AREA_SELECT] = area_select_q;
        rd_mux[LCDRC_POS_REVERSE_VID] = reverse_vid_q;
        rd_mux[LCDRC_POS_DISPLAY_MODE +: 2] = display_mode_q;
      end
      LCDRC_IDX_CONTRAST_ADJUST: rd_mux[LCDRC_POS_CONTRAST +: 4] = contrast_q;
      LCDRC_IDX_DUTY_CONTROL:    rd_mux[LCDRC_POS_DUTY +: 2] = duty_q;
      LCDRC_IDX_REGULATOR_CTRL:  rd_mux[LCDRC_POS_HEAVY_LOAD] = heavy_load_q;
      LCDRC_IDX_BOOSTER_CTRL: begin
        rd_mux[LCDRC_POS_REG_SOURCE] = reg_source_q;
        rd_mux[LCDRC_POS_BOOSTER_EN] = booster_en_q;
      end
      LCDRC_IDX_INTERRUPT_MASK:  rd_mux[LCDRC_POS_FRAME_IE] = frame_ie_q;
      LCDRC_IDX_INTERRUPT_FLAG:  rd_mux[LCDRC_POS_FRAME_IF] = frame_if_q;
      default:                   rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      hrdata_q <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seg_orient_q   <= LCDRC_RST_SEG_ORIENT;
      com_orient_q   <= LCDRC_RST_COM_ORIENT;
      area_select_q  <= LCDRC_RST_AREA_SELECT;
      reverse_vid_q  <= LCDRC_RST_REVERSE_VID;
      display_mode_q <= LCDRC_RST_DISPLAY_MODE;
    end else if (wr_fire && addr_q == LCDRC_IDX_DISPLAY_CONTROL) begin
      seg_orient_q   <= hwdata[LCDRC_POS_SEG_ORIENT];
      com_orient_q   <= hwdata[LCDRC_POS_COM_ORIENT];
      area_select_q  <= hwdata[LCDRC_POS_AREA_SELECT];
      reverse_vid_q  <= hwdata[LCDRC_POS_REVERSE_VID];
      display_mode_q <= hwdata[LCDRC_POS_DISPLAY_MODE +: 2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      contrast_q <= LCDRC_RST_CONTRAST;
      duty_q     <= LCDRC_RST_DUTY;
    end else if (wr_fire) begin
      if (addr_q == LCDRC_IDX_CONTRAST_ADJUST) begin
        contrast_q <= hwdata[LCDRC_POS_CONTRAST +: 4];
      end
      // The reserved duty codes are stored as written; the output stage decides what they do.
      if (addr_q == LCDRC_IDX_DUTY_CONTROL) begin
        duty_q <= hwdata[LCDRC_POS_DUTY +: 2];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      heavy_load_q <= LCDRC_RST_HEAVY_LOAD;
      reg_source_q <= LCDRC_RST_REG_SOURCE;
      booster_en_q <= LCDRC_RST_BOOSTER_EN;
    end else if (wr_fire) begin
      if (addr_q == LCDRC_IDX_REGULATOR_CTRL) begin
        heavy_load_q <= hwdata[LCDRC_POS_HEAVY_LOAD];
      end
      if (addr_q == LCDRC_IDX_BOOSTER_CTRL) begin
        reg_source_q <= hwdata[LCDRC_POS_REG_SOURCE];
        booster_en_q <= hwdata[LCDRC_POS_BOOSTER_EN];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_ie_q <= LCDRC_RST_FRAME_IE;
    end else if (wr_fire && addr_q == LCDRC_IDX_INTERRUPT_MASK) begin
      frame_ie_q <= hwdata[LCDRC_POS_FRAME_IE];
    end
  end

  // A frame event in the same cycle as a clearing write keeps the flag set,
  // so no frame is lost to a racing clear.
  always_comb begin
    frame_if_d = frame_if_q;
    if (wr_fire && addr_q == LCDRC_IDX_INTERRUPT_FLAG && hwdata[LCDRC_POS_FRAME_IF]) begin
      frame_if_d = 1'b0;
    end
    if (frame_event) begin
      frame_if_d = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_if_q <= LCDRC_RST_FRAME_IF;
    end else begin
      frame_if_q <= frame_if_d;
    end
  end

  // Registered so the output is glitch free; it trails the flag by one cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_irq_q <= 1'b0;
    end else begin
      frame_irq_q <= frame_if_q && frame_ie_q;
    end
  end

  assign hrdata              = hrdata_q;
  assign hreadyout           = hreadyout_q;
  assign hresp               = hresp_q;
  assign segment_orientation = seg_orient_q;
  assign common_orientation  = com_orient_q;
  assign display_area_select = area_select_q;
  assign reverse_video       = reverse_vid_q;
  assign display_mode        = display_mode_q;
  assign contrast_level      = contrast_q;
  assign duty_select         = duty_q;
  assign heavy_load_protect  = heavy_load_q;
  assign regulator_source    = reg_source_q;
  assign booster_enable      = booster_en_q;
  assign frame_irq           = frame_irq_q;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic wr_dctl;
  logic wr_regc;
  logic wr_pwr;
  logic wr_mask;
  logic wr_flag;

  assign wr_dctl = wr_fire && addr_q == LCDRC_IDX_DISPLAY_CONTROL;
  assign wr_regc = wr_fire && addr_q == LCDRC_IDX_REGULATOR_CTRL;
  assign wr_pwr  = wr_fire && addr_q == LCDRC_IDX_BOOSTER_CTRL;
  assign wr_mask = wr_fire && addr_q == LCDRC_IDX_INTERRUPT_MASK;
  assign wr_flag = wr_fire && addr_q == LCDRC_IDX_INTERRUPT_FLAG;

  chk_seg_orient_write: assert property (
    wr_dctl |=> segment_orientation == $past(hwdata[7]) && common_orientation == $past(hwdata[6]))
    else $error("segment orientation did not follow the display control write");

  chk_com_orient_hold: assert property (
    !wr_dctl |=> $stable(common_orientation) && $stable(segment_orientation))
    else $error("orientation changed without a display control write");

  chk_area_select_write: assert property (
    wr_dctl ##1 !wr_dctl |-> display_area_select == $past(hwdata[5]))
    else $error("display area select does not hold the written value");

  chk_heavy_load_write: assert property (
    wr_regc |=> heavy_load_protect == $past(hwdata[4]) && $stable(booster_enable))
    else $error("heavy load protection did not follow the regulator write");

  chk_reg_source_write: assert property (
    wr_pwr |=> regulator_source == $past(hwdata[1]))
    else $error("regulator source did not follow the booster control write");

  chk_booster_enable_write: assert property (
    wr_pwr |=> booster_enable == $past(hwdata[0]))
    else $error("booster enable did not follow the booster control write");

  chk_frame_ie_write: assert property (
    wr_mask |=> frame_ie_q == $past(hwdata[0]))
    else $error("frame interrupt enable did not follow the mask write");

  chk_frame_flag_set: assert property (
    frame_event |=> frame_if_q)
    else $error("frame event did not set the frame flag");

  chk_frame_flag_w1c: assert property (
    wr_flag && !frame_event |=> frame_if_q == ($past(frame_if_q) && !$past(hwdata[0])))
    else $error("frame flag did not obey write one to clear");

  chk_frame_flag_sticky: assert property (
    frame_if_q && !wr_flag |=> frame_if_q)
    else $error("frame flag cleared without a write");

  chk_frame_irq_level: assert property (
    ##1 frame_irq == $past(frame_if_q && frame_ie_q))
    else $error("frame interrupt request does not match flag and enable");

  chk_read_wait_state: assert property (
    addr_phase && !hwrite |=> !hreadyout ##1 (hreadyout && hrdata[31:8] == 24'h00_0000))
    else $error("read did not complete after exactly one wait state");

  // A stray address decode would move a field without its own write.
  // Display control, regulator, booster and mask fields are therefore held steady between writes to their own register.

  chk_area_select_hold: assert property (
    !wr_dctl |=> $stable(display_area_select) && $stable(reverse_video) && $stable(display_mode))
    else $error("display control field changed without a display control write");

  chk_heavy_load_hold: assert property (
    !wr_regc |=> $stable(heavy_load_protect))
    else $error("heavy load protection changed without a regulator write");

  chk_booster_hold: assert property (
    !wr_pwr |=> $stable(regulator_source) && $stable(booster_enable))
    else $error("booster control changed without a booster control write");

  chk_frame_ie_hold: assert property (
    !wr_mask |=> $stable(frame_ie_q))
    else $error("frame interrupt enable changed without a mask write");

  chk_irq_masked_low: assert property (
    !frame_ie_q |=> !frame_irq)
    else $error("frame interrupt request raised while the enable is clear");

  chk_dctl_other_fields: assert property (
    wr_dctl |=> reverse_video == $past(hwdata[4]) && display_mode == $past(hwdata[1:0]))
    else $error("reverse video or display mode did not follow the display control write");

  chk_contrast_write: assert property (
    wr_fire && addr_q == LCDRC_IDX_CONTRAST_ADJUST |=> contrast_level == $past(hwdata[3:0]))
    else $error("contrast level did not follow the contrast write");

  chk_duty_write: assert property (
    wr_fire && addr_q == LCDRC_IDX_DUTY_CONTROL |=> duty_select == $past(hwdata[1:0]))
    else $error("duty select did not follow the duty write");

  // Writes never wait; only reads pay the one wait state.
  chk_write_no_wait: assert property (
    addr_phase && hwrite |=> hreadyout)
    else $error("write inserted a wait state");

  chk_hresp_okay: assert property (
    hresp == LCDRC_HRESP_OKAY)
    else $error("slave answered with an error response");

  chk_read_reserved_zero: assert property (
    rd_pend_q && addr_q == LCDRC_IDX_REGULATOR_CTRL |=> hrdata[7:0] == {3'h0, $past(heavy_load_q), 4'h0})
    else $error("regulator read data misplaced the protection bit or showed reserved bits");

  cov_irq_raised: cover property (frame_ie_q && frame_event ##2 frame_irq);
  cov_clear_race: cover property (wr_flag && hwdata[0] && frame_event);
  cov_flag_cleared: cover property (frame_if_q && wr_flag && hwdata[0] && !frame_event ##1 !frame_if_q);
  cov_dctl_read: cover property (addr_phase && !hwrite && haddr[31:2] == LCDRC_IDX_DISPLAY_CONTROL);
  cov_booster_on: cover property (wr_pwr && hwdata[0] ##1 booster_enable);

endmodule // lcdrc_regs

// ==== design/lcdrc_pkg.sv ====
// Register map, field positions, reset values and bus constants of the LCD driver control bank.
package lcdrc_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [29:0] LCDRC_IDX_DISPLAY_CONTROL = 30'h0000_50a0;
  localparam logic [29:0] LCDRC_IDX_CONTRAST_ADJUST = 30'h0000_50a1;
  localparam logic [29:0] LCDRC_IDX_DUTY_CONTROL    = 30'h0000_50a2;
  localparam logic [29:0] LCDRC_IDX_REGULATOR_CTRL  = 30'h0000_50a3;
  localparam logic [29:0] LCDRC_IDX_BOOSTER_CTRL    = 30'h0000_50a4;
  localparam logic [29:0] LCDRC_IDX_INTERRUPT_MASK  = 30'h0000_50a5;
  localparam logic [29:0] LCDRC_IDX_INTERRUPT_FLAG  = 30'h0000_50a6;

  // Field positions inside the 8-bit registers.
  localparam int unsigned LCDRC_POS_SEG_ORIENT   = 7;
  localparam int unsigned LCDRC_POS_COM_ORIENT   = 6;
  localparam int unsigned LCDRC_POS_AREA_SELECT  = 5;
  localparam int unsigned LCDRC_POS_REVERSE_VID  = 4;
  localparam int unsigned LCDRC_POS_DISPLAY_MODE = 0;
  localparam int unsigned LCDRC_POS_CONTRAST     = 0;
  localparam int unsigned LCDRC_POS_DUTY         = 0;
  localparam int unsigned LCDRC_POS_HEAVY_LOAD   = 4;
  localparam int unsigned LCDRC_POS_REG_SOURCE   = 1;
  localparam int unsigned LCDRC_POS_BOOSTER_EN   = 0;
  localparam int unsigned LCDRC_POS_FRAME_IE     = 0;
  localparam int unsigned LCDRC_POS_FRAME_IF     = 0;

  // Values after reset.
  localparam logic       LCDRC_RST_SEG_ORIENT   = 1'b1;
  localparam logic       LCDRC_RST_COM_ORIENT   = 1'b1;
  localparam logic       LCDRC_RST_AREA_SELECT  = 1'b0;
  localparam logic       LCDRC_RST_REVERSE_VID  = 1'b1;
  localparam logic [1:0] LCDRC_RST_DISPLAY_MODE = 2'h0;
  localparam logic [3:0] LCDRC_RST_CONTRAST     = 4'h0;
  localparam logic [1:0] LCDRC_RST_DUTY         = 2'h2;
  localparam logic       LCDRC_RST_HEAVY_LOAD   = 1'b0;
  localparam logic       LCDRC_RST_REG_SOURCE   = 1'b0;
  localparam logic       LCDRC_RST_BOOSTER_EN   = 1'b0;
  localparam logic       LCDRC_RST_FRAME_IE     = 1'b0;
  localparam logic       LCDRC_RST_FRAME_IF     = 1'b0;

  // AHB-Lite encodings.
  localparam logic [1:0] LCDRC_HTRANS_NONSEQ = 2'h2;
  localparam logic       LCDRC_HRESP_OKAY    = 1'b0;

  // Display mode encodings.
  typedef enum logic [1:0] {
    LCDRC_MODE_OFF = 2'h0,
    LCDRC_MODE_NORMAL = 2'h1,
    LCDRC_MODE_ALL_ON = 2'h2,
    LCDRC_MODE_ALL_OFF = 2'h3
  } lcdrc_mode_t;

endpackage : lcdrc_pkg

// ==== dv/lcdrc_regs_tb_top.sv ====
// Self-checking testbench of the LCD driver control register bank.
module lcdrc_regs_tb_top import lcdrc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        frame_event;
  logic        seg_o;
  logic        com_o;
  logic        area_o;
  logic        rev_o;
  logic [1:0]  mode_o;
  logic [3:0]  contrast_o;
  logic [1:0]  duty_o;
  logic        heavy_o;
  logic        source_o;
  logic        boost_o;
  logic        frame_irq;
  logic [7:0]  mdl [0:7];
  logic [31:0] rd;
  int          miscompares = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          seed = 12;
  int          k;

  // Writable bits of each register; slot 7 stands for an unmapped word.
  localparam logic [7:0] WMASK [0:7] = '{8'hf3, 8'h0f, 8'h03, 8'h10, 8'h03, 8'h01, 8'h01, 8'h00};

  lcdrc_regs i_dut (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (hsize),
    .hwdata              (hwdata),
    .hready              (hreadyout),
    .hrdata              (hrdata),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .frame_event         (frame_event),
    .segment_orientation (seg_o),
    .common_orientation  (com_o),
    .display_area_select (area_o),
    .reverse_video       (rev_o),
    .display_mode        (mode_o),
    .contrast_level      (contrast_o),
    .duty_select         (duty_o),
    .heavy_load_protect  (heavy_o),
    .regulator_source    (source_o),
    .booster_enable      (boost_o),
    .frame_irq           (frame_irq)
  );

  // The flag register only loses bits written as one; all others store the writable bits.
  function automatic logic [7:0] exp_wr(int r, logic [7:0] old, logic [7:0] wd);
    return (r == 6) ? (old & ~(wd & 8'h01)) : (wd & WMASK[r]);
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Called just after a rising edge; returns at the edge that ends the data phase.
  task automatic bus(logic wr, int r, logic [31:0] wd, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {LCDRC_IDX_DISPLAY_CONTROL + 30'(r), 2'b00};
    htrans <= LCDRC_HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  // The interrupt output is registered, so two settled cycles pass before it is judged.
  task automatic fields();
    logic [14:0] ex;
    logic [14:0] sn;
    repeat (2) @(negedge hclk);
    ex = {mdl[0][7:4], mdl[0][1:0], mdl[1][3:0], mdl[2][1:0], mdl[3][4], mdl[4][1:0]};
    sn = {seg_o, com_o, area_o, rev_o, mode_o, contrast_o, duty_o, heavy_o, source_o, boost_o};
    chk("fields", 32'(ex), 32'(sn));
    chk("frame_irq", 32'(mdl[5][0] & mdl[6][0]), 32'(frame_irq));
    chk("hresp", 32'(LCDRC_HRESP_OKAY), 32'(hresp));
    @(posedge hclk);
  endtask

  task automatic wr(int r, logic [31:0] wd);
    bus(1'b1, r, wd, rd);
    mdl[r] = exp_wr(r, mdl[r], wd[7:0]);
    fields();
  endtask

  task automatic rdchk(int r);
    bus(1'b0, r, 32'h0000_0000, rd);
    chk("read data", {24'h00_0000, mdl[r]}, rd);
  endtask

  task automatic pulse();
    frame_event <= 1'b1;
    @(posedge hclk);
    frame_event <= 1'b0;
    mdl[6] = 8'h01;
    fields();
  endtask

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    frame_event = 1'b0;
    mdl = '{8'hd0, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    fields();
    for (int r = 0; r < 8; r++) rdchk(r);
    $display("test reset values done");
    for (int v = 0; v < 4; v++) begin
      wr(0, 32'(v) * 32'h0000_0055);
      rdchk(0);
    end
    for (int r = 0; r < 8; r++) begin
      wr(r, 32'hffff_ffff);
      rdchk(r);
      wr(r, 32'h0000_0000);
      rdchk(r);
    end
    $display("test corner values done");
    repeat (80) begin
      k = $unsigned($random(seed)) % 8;
      if ($random(seed) & 1) begin
        wr(k, $random(seed));
      end else begin
        rdchk(k);
      end
    end
    $display("test random access done");
    wr(5, 32'h0000_0000);
    wr(6, 32'h0000_0001);
    pulse();
    rdchk(6);
    wr(6, 32'hffff_fffe);
    rdchk(6);
    wr(5, 32'h0000_0001);
    wr(5, 32'h0000_0000);
    wr(5, 32'h0000_0001);
    wr(6, 32'h0000_0001);
    rdchk(6);
    // A frame event that meets a clearing write must leave the flag set.
    frame_event <= 1'b1;
    bus(1'b1, 6, 32'h0000_0001, rd);
    frame_event <= 1'b0;
    mdl[6] = 8'h01;
    fields();
    rdchk(6);
    wr(6, 32'h0000_0001);
    rdchk(6);
    pulse();
    $display("test frame interrupt done");
    close_out();
  end

endmodule // lcdrc_regs_tb_top
